/* common/tpt_pkg.sv */
// Package for the triggered pulse timer: register map, field positions,
// mode and edge encodings, and reset values.
// Assumes a 16-bit register port with byte-wide word indices.
package tpt_pkg;
    // Register word addresses
    localparam logic [7:0] ADDR_CTL0 = 8'h00;  // control_reg_zero
    localparam logic [7:0] ADDR_CTL1 = 8'h01;  // control_reg_one
    localparam logic [7:0] ADDR_IOC0 = 8'h02;  // io_control_reg_zero
    localparam logic [7:0] ADDR_IOC2 = 8'h03;  // io_control_reg_two
    localparam logic [7:0] ADDR_CYC = 8'h04;   // cycle_compare_reg
    localparam logic [7:0] ADDR_DUTY = 8'h05;  // duty_compare_reg
    localparam logic [7:0] ADDR_CNT = 8'h06;   // counter_readback_reg
    // Field positions
    localparam int CE_BIT = 7;       // count_enable_bit in control_reg_zero
    localparam int CKS_LSB = 0;      // count_clock_select_field, 3 bits
    localparam int EST_BIT = 6;      // software_trigger_bit in control_reg_one
    localparam int MD_LSB = 0;       // mode_select_field, 3 bits
    localparam int AUX_EN_BIT = 0;   // io_control_reg_zero fields
    localparam int AUX_INV_BIT = 1;
    localparam int PWM_EN_BIT = 2;
    localparam int PWM_INV_BIT = 3;
    localparam int ETS_LSB = 0;      // trigger edge select, 2 bits
    localparam int EES_LSB = 2;      // event edge select, 2 bits, stored only
    // Encodings
    localparam logic [2:0] MODE_TRIG_PWM = 3'h2;
    localparam logic [2:0] MODE_ONESHOT = 3'h3;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Reset and special values
    localparam logic [15:0] CNT_IDLE = 16'h0000;
    localparam logic [15:0] CNT_WAIT = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] DUTY_ZERO = 16'h0000;
    localparam logic [15:0] RD_ZERO = 16'h0000;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [7:0] PRE_ONE = 8'h01;
    localparam logic [7:0] PRE_ZERO = 8'h00;

    // Timer sequencing states
    typedef enum logic [2:0] {
        TPT_IDLE = 3'b001,
        TPT_WAIT = 3'b010,
        TPT_RUN = 3'b100
    } tpt_state_t;
endpackage

/* verilog/tpt_timer.sv */
// Triggered pulse timer: triggered PWM and one-shot modes on a 16-bit counter
// with double-buffered compare values and a simple register port.
// Assumes all inputs are synchronous to clk; trigger pin is already clean.
//
// Summary of operation
// - Triggered PWM: period is cycle value plus one counts, width equals duty value.
// - After a duty write, both compares load into buffers at next counter clear.
// - Only a duty write arms the buffer reload; cycle write alone does not.
// - Duty zero gives 0% output; both interrupts fire at the clear after cycle match.
// - Duty equal to cycle plus one gives 100%; impossible with cycle FFFFH.
// - Trigger after duty match clears counter, asserts PWM output, keeps counting.
// - Trigger before duty match suppresses it, clears counter, output stays active.
// - Trigger after cycle match clears counter and keeps counting.
// - Trigger before cycle match suppresses it, clears counter, asserts output.
// - In triggered PWM the duty interrupt fires when count equals duty buffer.
// - Mode 011 is one-shot; enable waits for trigger, trigger yields one pulse.
// - One-shot: auxiliary output active while counting, inactive while waiting.
// - One-shot counts from 0000H up to the cycle value, stops at 0000H, ignores retriggers.
// - One-shot delay is duty counts; width is cycle minus duty plus one.
// - One-shot cycle interrupt on count after cycle match; duty on equal count.
// - Trigger is selected edge on trigger input or software trigger bit write.
// - Counter read-back register returns the live counter value.
// - Clock select accepted in the same write that sets the enable bit.
// - Mode 010 is triggered PWM; enable enters trigger wait before counting.
// - Trigger while counting in triggered PWM clears and restarts; PWM goes high, aux toggles.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module tpt_timer #(
    parameter int CNT_W = 16,
    parameter int PRE_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic external_trigger_input,
    output logic pwm_timer_output,
    output logic aux_timer_output,
    output logic cycle_match_irq,
    output logic duty_match_irq,
    output logic oneshot_cycle_match_irq,
    output logic oneshot_duty_match_irq
);
    // Software registers
    logic ce, next_ce;
    logic [2:0] cks, next_cks;
    logic [2:0] mode, next_mode;
    logic [3:0] ioc0, next_ioc0;
    logic [3:0] ioc2, next_ioc2;
    logic [CNT_W-1:0] cyc_reg, next_cyc_reg;
    logic [CNT_W-1:0] duty_reg, next_duty_reg;
    // Timer state
    tpt_pkg::tpt_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [CNT_W-1:0] cyc_buf, next_cyc_buf;
    logic [CNT_W-1:0] duty_buf, next_duty_buf;
    logic reload_pend, next_reload_pend;
    logic trig_pend, next_trig_pend;
    logic [PRE_W-1:0] pre, next_pre;
    logic trig_prev, next_trig_prev;
    logic pwm_lvl, next_pwm_lvl;
    logic aux_lvl, next_aux_lvl;
    logic next_pwm_pin, next_aux_pin;
    logic next_cyc_irq, next_duty_irq;
    logic [15:0] next_rdata;
    logic tick, trig_now, clear_now, match_cyc;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] clr_duty;

    // Selected valid edge on the trigger pin
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        case (sel)
            tpt_pkg::EDGE_RISE: edge_hit = cur & ~prev;
            tpt_pkg::EDGE_FALL: edge_hit = ~cur & prev;
            tpt_pkg::EDGE_BOTH: edge_hit = cur ^ prev;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // Count clock tick: divide clk by 2 to the power of the clock select
    function automatic logic pre_done(input logic [PRE_W-1:0] p, input logic [2:0] sel);
        logic [PRE_W-1:0] lim;
        lim = PRE_W'((1 << sel) - 1);
        pre_done = (p >= lim);
    endfunction

    // Next-value logic for registers, counter, buffers and outputs
    always_comb begin
        next_ce = ce;
        next_cks = cks;
        next_mode = mode;
        next_ioc0 = ioc0;
        next_ioc2 = ioc2;
        next_cyc_reg = cyc_reg;
        next_duty_reg = duty_reg;
        next_state = state;
        next_cnt = cnt;
        next_cyc_buf = cyc_buf;
        next_duty_buf = duty_buf;
        next_reload_pend = reload_pend;
        next_trig_pend = trig_pend;
        next_pre = pre;
        next_trig_prev = external_trigger_input;
        next_pwm_lvl = pwm_lvl;
        next_aux_lvl = aux_lvl;
        next_cyc_irq = 1'b0;
        next_duty_irq = 1'b0;
        next_rdata = tpt_pkg::RD_ZERO;
        tick = 1'b0;
        clear_now = 1'b0;
        match_cyc = 1'b0;
        cnt_inc = cnt + tpt_pkg::CNT_STEP;
        // Duty value in force after a clear in this cycle, pending reload included
        clr_duty = reload_pend ? duty_reg : duty_buf;
        // Pin edge or software trigger bit written as one
        trig_now = edge_hit(ioc2[tpt_pkg::ETS_LSB +: 2], trig_prev, external_trigger_input);
        if (wr && addr == tpt_pkg::ADDR_CTL1 && wdata[tpt_pkg::EST_BIT]) begin
            trig_now = 1'b1;
        end

        // Register writes
        if (wr) begin
            case (addr)
                tpt_pkg::ADDR_CTL0: begin
                    next_ce = wdata[tpt_pkg::CE_BIT];
                    next_cks = wdata[tpt_pkg::CKS_LSB +: 3];
                end
                tpt_pkg::ADDR_CTL1: next_mode = wdata[tpt_pkg::MD_LSB +: 3];
                tpt_pkg::ADDR_IOC0: next_ioc0 = wdata[3:0];
                tpt_pkg::ADDR_IOC2: next_ioc2 = wdata[3:0];
                tpt_pkg::ADDR_CYC: next_cyc_reg = wdata[CNT_W-1:0];
                tpt_pkg::ADDR_DUTY: begin
                    next_duty_reg = wdata[CNT_W-1:0];
                    next_reload_pend = 1'b1;
                end
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle
        if (rd) begin
            case (addr)
                tpt_pkg::ADDR_CTL0: next_rdata = 16'({ce, 4'h0, cks});
                tpt_pkg::ADDR_CTL1: next_rdata = 16'(mode);
                tpt_pkg::ADDR_IOC0: next_rdata = 16'(ioc0);
                tpt_pkg::ADDR_IOC2: next_rdata = 16'(ioc2);
                tpt_pkg::ADDR_CYC: next_rdata = 16'(cyc_reg);
                tpt_pkg::ADDR_DUTY: next_rdata = 16'(duty_reg);
                tpt_pkg::ADDR_CNT: next_rdata = 16'(cnt);
                default: next_rdata = tpt_pkg::RD_ZERO;
            endcase
        end

        // Count clock prescaler runs only in the run state, not while waiting for a trigger
        if (state == tpt_pkg::TPT_RUN) begin
            if (pre_done(pre, cks)) begin
                tick = 1'b1;
                next_pre = tpt_pkg::PRE_ZERO[PRE_W-1:0];
            end else begin
                next_pre = pre + tpt_pkg::PRE_ONE[PRE_W-1:0];
            end
        end else begin
            next_pre = tpt_pkg::PRE_ZERO[PRE_W-1:0];
        end

        // While running in triggered PWM, triggers are held until the next count tick; a new one wins over consume
        if (trig_now) begin
            next_trig_pend = 1'b1;
        end

        case (state)
            tpt_pkg::TPT_IDLE: begin
                next_trig_pend = 1'b0;
                if (ce) begin
                    // Enable enters trigger wait with freshly loaded buffers
                    next_state = tpt_pkg::TPT_WAIT;
                    next_cnt = tpt_pkg::CNT_WAIT;
                    next_cyc_buf = cyc_reg;
                    next_duty_buf = duty_reg;
                    next_reload_pend = wr && addr == tpt_pkg::ADDR_DUTY;
                end
            end
            tpt_pkg::TPT_WAIT: begin
                if (trig_now) begin
                    // Counter goes to 0000H on the trigger, from FFFFH after enable or staying 0000H after a one-shot pulse
                    next_state = tpt_pkg::TPT_RUN;
                    next_trig_pend = 1'b0;
                    clear_now = 1'b1;
                    if (mode == tpt_pkg::MODE_ONESHOT) begin
                        next_aux_lvl = 1'b1;
                        next_pwm_lvl = (clr_duty == tpt_pkg::DUTY_ZERO);
                        next_duty_irq = (clr_duty == tpt_pkg::DUTY_ZERO);
                    end else begin
                        next_aux_lvl = ~aux_lvl;
                        next_pwm_lvl = (clr_duty != tpt_pkg::DUTY_ZERO);
                    end
                end
            end
            tpt_pkg::TPT_RUN: begin
                match_cyc = (cnt == cyc_buf);
                if (mode == tpt_pkg::MODE_ONESHOT) begin
                    next_trig_pend = 1'b0;
                    if (tick) begin
                        if (match_cyc) begin
                            // Pulse over: clear, stop and wait for the next trigger
                            clear_now = 1'b1;
                            next_state = tpt_pkg::TPT_WAIT;
                            next_pwm_lvl = 1'b0;
                            next_aux_lvl = 1'b0;
                            next_cyc_irq = 1'b1;
                        end else begin
                            next_cnt = cnt_inc;
                            if (cnt_inc == duty_buf) begin
                                next_pwm_lvl = 1'b1;
                                next_duty_irq = 1'b1;
                            end
                        end
                    end
                end else if (tick) begin
                    if (trig_pend) begin
                        // Restart: both pending matches this tick are dropped
                        next_trig_pend = trig_now;
                        clear_now = 1'b1;
                        next_aux_lvl = ~aux_lvl;
                        next_pwm_lvl = (clr_duty != tpt_pkg::DUTY_ZERO);
                    end else if (match_cyc) begin
                        // Period end one count after the cycle match
                        clear_now = 1'b1;
                        next_cyc_irq = 1'b1;
                        next_aux_lvl = ~aux_lvl;
                        next_pwm_lvl = (clr_duty != tpt_pkg::DUTY_ZERO);
                        next_duty_irq = (clr_duty == tpt_pkg::DUTY_ZERO);
                    end else begin
                        next_cnt = cnt_inc;
                        if (cnt_inc == duty_buf) begin
                            next_pwm_lvl = 1'b0;
                            next_duty_irq = 1'b1;
                        end
                    end
                end
            end
            default: next_state = tpt_pkg::TPT_IDLE;
        endcase

        // Clearing the counter takes pending compare values into the buffers
        if (clear_now) begin
            next_cnt = tpt_pkg::CNT_ZERO;
            if (reload_pend) begin
                next_cyc_buf = cyc_reg;
                next_duty_buf = duty_reg;
                next_reload_pend = wr && addr == tpt_pkg::ADDR_DUTY;
            end
        end

        // Disable overrides everything and parks the timer
        if (!ce) begin
            next_state = tpt_pkg::TPT_IDLE;
            next_cnt = tpt_pkg::CNT_IDLE;
            next_pwm_lvl = 1'b0;
            next_aux_lvl = 1'b0;
            next_trig_pend = 1'b0;
            next_cyc_irq = 1'b0;
            next_duty_irq = 1'b0;
        end

        // Pin levels with enable and polarity
        next_aux_pin = next_ioc0[tpt_pkg::AUX_EN_BIT] & (next_aux_lvl ^ next_ioc0[tpt_pkg::AUX_INV_BIT]);
        next_pwm_pin = next_ioc0[tpt_pkg::PWM_EN_BIT] & (next_pwm_lvl ^ next_ioc0[tpt_pkg::PWM_INV_BIT]);
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ce <= 1'b0;
            cks <= 3'h0;
            mode <= 3'h0;
            ioc0 <= 4'h0;
            ioc2 <= 4'h0;
            cyc_reg <= tpt_pkg::CMP_RESET;
            duty_reg <= tpt_pkg::CMP_RESET;
            state <= tpt_pkg::TPT_IDLE;
            cnt <= tpt_pkg::CNT_IDLE;
            cyc_buf <= tpt_pkg::CMP_RESET;
            duty_buf <= tpt_pkg::CMP_RESET;
            reload_pend <= 1'b0;
            trig_pend <= 1'b0;
            pre <= tpt_pkg::PRE_ZERO[PRE_W-1:0];
            trig_prev <= 1'b0;
            pwm_lvl <= 1'b0;
            aux_lvl <= 1'b0;
            pwm_timer_output <= 1'b0;
            aux_timer_output <= 1'b0;
            cycle_match_irq <= 1'b0;
            duty_match_irq <= 1'b0;
            oneshot_cycle_match_irq <= 1'b0;
            oneshot_duty_match_irq <= 1'b0;
            rdata <= tpt_pkg::RD_ZERO;
        end else begin
            ce <= next_ce;
            cks <= next_cks;
            mode <= next_mode;
            ioc0 <= next_ioc0;
            ioc2 <= next_ioc2;
            cyc_reg <= next_cyc_reg;
            duty_reg <= next_duty_reg;
            state <= next_state;
            cnt <= next_cnt;
            cyc_buf <= next_cyc_buf;
            duty_buf <= next_duty_buf;
            reload_pend <= next_reload_pend;
            trig_pend <= next_trig_pend;
            pre <= next_pre;
            trig_prev <= next_trig_prev;
            pwm_lvl <= next_pwm_lvl;
            aux_lvl <= next_aux_lvl;
            pwm_timer_output <= next_pwm_pin;
            aux_timer_output <= next_aux_pin;
            cycle_match_irq <= next_cyc_irq && mode != tpt_pkg::MODE_ONESHOT;
            duty_match_irq <= next_duty_irq && mode != tpt_pkg::MODE_ONESHOT;
            oneshot_cycle_match_irq <= next_cyc_irq && mode == tpt_pkg::MODE_ONESHOT;
            oneshot_duty_match_irq <= next_duty_irq && mode == tpt_pkg::MODE_ONESHOT;
            rdata <= next_rdata;
        end
    end
endmodule // tpt_timer

/* dv/tpt_props.sv */
// Port checker for the triggered pulse timer.
// Assumes it is bound to tpt_timer and sees only that module's ports.
module tpt_props #(
    parameter int CNT_W = 16,
    parameter int PRE_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic aux_timer_output,
    input wire logic cycle_match_irq,
    input wire logic duty_match_irq,
    input wire logic oneshot_cycle_match_irq,
    input wire logic oneshot_duty_match_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Interrupt pulses last one cycle
    AST_CYC_PULSE: assert property (cycle_match_irq |=> !cycle_match_irq)
        else $error("Cycle irq longer than one cycle");
    AST_DUTY_PULSE: assert property ($rose(duty_match_irq) |=> $fell(duty_match_irq))
        else $error("Duty irq longer than one cycle");
    AST_OS_PULSE: assert property (oneshot_cycle_match_irq |-> ##1 !oneshot_cycle_match_irq)
        else $error("One-shot cycle irq too long");
    // Each mode drives its own pair of requests
    AST_MODE_SPLIT: assert property ((cycle_match_irq || duty_match_irq)
        |-> !(oneshot_cycle_match_irq || oneshot_duty_match_irq))
        else $error("Both irq pairs active");
    AST_OS_ORDER: assert property (not (oneshot_cycle_match_irq && oneshot_duty_match_irq))
        else $error("One-shot irqs together");
    // Read data only in the cycle after a read
    AST_RD_QUIET: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("Read data outside read slot");
    AST_EST_READ: assert property (rd && addr == tpt_pkg::ADDR_CTL1 |=> !rdata[tpt_pkg::EST_BIT])
        else $error("Software trigger bit reads one");
    // Stopping silences every request
    AST_STOP_QUIET: assert property (wr && addr == tpt_pkg::ADDR_CTL0 && !wdata[tpt_pkg::CE_BIT] |-> ##2
        !(cycle_match_irq || duty_match_irq || oneshot_cycle_match_irq || oneshot_duty_match_irq))
        else $error("Irq after stop");
    // Main scenarios
    cover property (cycle_match_irq);
    cover property (oneshot_duty_match_irq);
    cover property ($rose(aux_timer_output));
endmodule // tpt_props

/* dv/tpt_load.sv */
// Far-side model: trigger source and a load that times the pulse pin.
// Assumes clk is the timer clock; the trigger line rests low.
module tpt_load (
    input wire logic clk,
    input wire logic trig_req,
    input wire logic arm,
    input wire logic pin,
    output logic trig_pin,
    output logic done,
    output logic [15:0] hi_w,
    output logic [15:0] lo_w
);
    logic prev = 1'b0;
    logic [15:0] hi_c = 16'h0000;
    logic [15:0] lo_c = 16'h0000;
    initial trig_pin = 1'b0;
    initial done = 1'b0;
    // Trigger line follows the request a cycle late
    always @(posedge clk) trig_pin <= trig_req;
    // Count high and low cycles; report widths at each fall while armed
    always @(posedge clk) begin
        prev <= pin;
        done <= arm && prev && !pin;
        if (!arm) begin
            hi_c <= 16'h0000;
            lo_c <= 16'h0000;
        end else if (pin) begin
            hi_c <= (prev ? hi_c : 16'h0000) + 16'h0001;
            if (!prev) lo_w <= lo_c;
        end else begin
            lo_c <= (prev ? 16'h0000 : lo_c) + 16'h0001;
            if (prev) hi_w <= hi_c;
        end
    end
endmodule // tpt_load

/* dv/tb.sv */
// Bench for the triggered pulse timer: register port, triggered PWM, one-shot.
// Assumes tpt_load on the pins and tpt_props bound to the design.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] EN = 16'h0080;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic trig_req = 1'b0;
    logic arm = 1'b0;
    logic ext, pwm, aux, done;
    logic [15:0] rdata, hi_w, lo_w;
    logic [31:0] q_rd[$];
    logic [31:0] q_pw[$];
    int error_cnt = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    tpt_timer i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .external_trigger_input(ext), .pwm_timer_output(pwm), .aux_timer_output(aux),
        .cycle_match_irq(), .duty_match_irq(), .oneshot_cycle_match_irq(), .oneshot_duty_match_irq());
    tpt_load i_load (.clk(clk), .trig_req(trig_req), .arm(arm), .pin(pwm), .trig_pin(ext),
        .done(done), .hi_w(hi_w), .lo_w(lo_w));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Compare each read and each reported pulse with the oldest note
    always @(posedge clk) begin
        logic [31:0] n;
        rd_q <= rd;
        if (rd_q && q_rd.size() == 0) begin
            check("rdata note", 16'h0001, 16'h0000);
        end else if (rd_q) begin
            n = q_rd.pop_front();
            check("rdata", rdata & n[31:16], n[15:0] & n[31:16]);
        end
        if (done && q_pw.size() == 0) begin
            check("pulse note", 16'h0001, 16'h0000);
        end else if (done) begin
            n = q_pw.pop_front();
            if (n[31:16] !== 16'hffff) check("low width", lo_w, n[31:16]);
            check("high width", hi_w, n[15:0]);
        end
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
        q_rd.push_back({m, e});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse();
        trig_req <= 1'b1;
        @(posedge clk);
        trig_req <= 1'b0;
    endtask
    // Bounded wait until every note has been matched
    task automatic drain();
        int n;
        for (n = 0; n < 3000 && q_rd.size() + q_pw.size() > 0; n++) @(posedge clk);
        if (n == 3000) begin
            check("drain", 16'h0001, 16'h0000);
            complete_run();
        end
    endtask
    initial begin
        logic [15:0] c, d, c2, lo, hi;
        int s;
        void'($urandom(86597));
        c = 16'h0008 + 16'($urandom % 8);
        d = 16'h0001 + 16'($urandom % 3);
        s = $urandom % 2;
        c2 = c - 16'h0003;
        lo = (c + 16'h0001 - d) << s;
        hi = d << s;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Register port and triggered PWM set-up
        rd_reg(8'h07, tpt_pkg::RD_ZERO);
        rd_reg(tpt_pkg::ADDR_CNT, tpt_pkg::CNT_IDLE);
        wr_reg(tpt_pkg::ADDR_CYC, c);
        wr_reg(tpt_pkg::ADDR_DUTY, d);
        wr_reg(tpt_pkg::ADDR_IOC0, 16'h0004);
        wr_reg(tpt_pkg::ADDR_IOC2, {14'h0000, tpt_pkg::EDGE_RISE});
        wr_reg(tpt_pkg::ADDR_CTL1, 16'h0040 | 16'(tpt_pkg::MODE_TRIG_PWM));
        rd_reg(tpt_pkg::ADDR_CTL1, 16'(tpt_pkg::MODE_TRIG_PWM));
        rd_reg(tpt_pkg::ADDR_CYC, c);
        wr_reg(tpt_pkg::ADDR_CTL0, EN | 16'(s));
        rd_reg(tpt_pkg::ADDR_CNT, tpt_pkg::CNT_WAIT);
        q_pw.push_back({16'hffff, hi});
        repeat (2) q_pw.push_back({lo, hi});
        arm <= 1'b1;
        pulse();
        drain();
        // A cycle write alone keeps the buffered period
        repeat (2) q_pw.push_back({lo, hi});
        wr_reg(tpt_pkg::ADDR_CYC, c2);
        drain();
        // Same duty rewritten: new period after the next clear
        q_pw.push_back({lo, hi});
        q_pw.push_back({(c2 + 16'h0001 - d) << s, hi});
        wr_reg(tpt_pkg::ADDR_DUTY, d);
        // No compare write until a full period has passed the clear
        drain();
        arm <= 1'b0;
        wr_reg(tpt_pkg::ADDR_CTL0, 16'h0000);
        rd_reg(tpt_pkg::ADDR_CNT, tpt_pkg::CNT_IDLE);
        // Every edge code; no detection leaves the timer waiting
        for (int e = 0; e < 4; e++) begin
            wr_reg(tpt_pkg::ADDR_IOC2, 16'(e));
            wr_reg(tpt_pkg::ADDR_CTL0, EN);
            pulse();
            repeat (4) @(posedge clk);
            rd_reg(tpt_pkg::ADDR_CNT, (e == 0) ? 16'hffff : 16'h0000, 16'h8000);
            wr_reg(tpt_pkg::ADDR_CTL0, 16'h0000);
        end
        // One-shot by software trigger, retrigger inside the pulse
        wr_reg(tpt_pkg::ADDR_CTL1, 16'(tpt_pkg::MODE_ONESHOT));
        wr_reg(tpt_pkg::ADDR_IOC0, 16'h0005);
        wr_reg(tpt_pkg::ADDR_CTL0, EN);
        for (int k = 0; k < 2; k++) begin
            // Low count includes the write cycle before the trigger is taken
            q_pw.push_back({d + 16'h0001, c2 - d + 16'h0001});
            arm <= 1'b1;
            wr_reg(tpt_pkg::ADDR_CTL1, 16'h0043);
            repeat (d) @(posedge clk);
            check("aux running", 16'(aux), 16'h0001);
            wr_reg(tpt_pkg::ADDR_CTL1, 16'h0043);
            drain();
            check("aux stopped", 16'(aux), 16'h0000);
            arm <= 1'b0;
            rd_reg(tpt_pkg::ADDR_CNT, tpt_pkg::CNT_ZERO);
        end
        drain();
        complete_run();
    end
endmodule // tb
bind tpt_timer tpt_props #(.CNT_W(CNT_W), .PRE_W(PRE_W)) i_props (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .aux_timer_output(aux_timer_output),
    .cycle_match_irq(cycle_match_irq), .duty_match_irq(duty_match_irq),
    .oneshot_cycle_match_irq(oneshot_cycle_match_irq), .oneshot_duty_match_irq(oneshot_duty_match_irq));
